// [verilog/hpc_pkg.sv]
package hpc_pkg;

  // Register offsets and field layout
  localparam logic [7:0] HPC_LIB_CFG_OFS  = 8'h0d;
  localparam logic [7:0] HPC_RT_DRIVE_OFS = 8'h0e;
  localparam logic [7:0] HPC_SLOT_ONE_OFS = 8'h0f;

  localparam int HPC_LIB_SEL_BIT  = 7;
  localparam int HPC_INTERVAL_BIT = 5;
  localparam int HPC_ATTEN_LSB    = 0;
  localparam int HPC_DELAY_BIT    = 7;

  localparam logic [7:0] HPC_LIB_CFG_RST  = 8'h00;
  localparam logic [7:0] HPC_RT_DRIVE_RST = 8'h7f;
  localparam logic [7:0] HPC_SLOT_ONE_RST = 8'h01;

  // Mode field codes seen on mode_i
  localparam logic [1:0] HPC_MODE_SEQ  = 2'h0;
  localparam logic [1:0] HPC_MODE_LIVE = 2'h1;

  localparam int HPC_SLOTS = 8;

  // Timing
  localparam int HPC_CLK_PERIOD_NS = 8;
  localparam int HPC_STEP_SLOW_NS  = 5_000_000;
  localparam int HPC_STEP_FAST_NS  = 1_000_000;
  localparam int HPC_WAIT_UNIT_NS  = 10_000_000;
  localparam int HPC_STEP_SLOW_CYC = HPC_STEP_SLOW_NS / HPC_CLK_PERIOD_NS;
  localparam int HPC_STEP_FAST_CYC = HPC_STEP_FAST_NS / HPC_CLK_PERIOD_NS;
  localparam int HPC_WAIT_UNIT_CYC = HPC_WAIT_UNIT_NS / HPC_CLK_PERIOD_NS;
  localparam int HPC_CNT_W         = 21;

  localparam int HPC_FIFO_W = 8;
  localparam int HPC_FIFO_D = 32;

  typedef enum logic [1:0] {
    HPC_IDLE,
    HPC_PLAY,
    HPC_WAIT,
    HPC_LIVE
  } hpc_state_e;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } hpc_reg_rsp_s;

endpackage

// [verilog/hpc_playback_regs.sv]
`timescale 1ns/100ps
// Contract
// - Library choice bit: 0 closed-loop resonant library, 1 open-loop rotating-mass.
// - Step period bit: 0 gives 5 ms library steps, 1 gives 1 ms.
// - Attenuation codes 0..3 play at 100, 75, 50, 25 percent.
// - Attenuation is not applied in live stream mode.
// - Live stream mode and triggered: drive the real-time value to the load.
// - Host may rewrite the real-time value anytime; each write is applied. While the FIFO is full, only the latest write is sent.
// - The real-time value is a two's-complement signed byte.
// - Fire starts selected process, stays high until done, clearing cancels.
// - Slot delay flag set: idle 10 ms times value; else waveform id.
// - Sequencer starts at slot one, runs up to eight slots, stops at zero.

module hpc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } hpc_fifo_s;

  hpc_fifo_s st;
  hpc_fifo_s next_st;
  logic      push;
  logic      pop;

  // Count has a spare bit so a full queue and an empty one differ
  // Read data is the stored word itself, so it holds while stalled
  assign in_ready_o  = (st.cnt != (AW+1)'(D));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = st.mem[st.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp         = (st.wp == AW'(D-1)) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(D-1)) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // Storage is cleared too; costs area but keeps every read defined
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module hpc_playback_regs #(
  parameter int STEP_SLOW_CYC = hpc_pkg::HPC_STEP_SLOW_CYC,
  parameter int STEP_FAST_CYC = hpc_pkg::HPC_STEP_FAST_CYC,
  parameter int WAIT_UNIT_CYC = hpc_pkg::HPC_WAIT_UNIT_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire hpc_pkg::hpc_reg_req_s reg_req_i,
  output hpc_pkg::hpc_reg_rsp_s      reg_rsp_o,
  input  wire logic [1:0]            mode_i,
  input  wire logic                  fire_set_i,
  input  wire logic                  fire_clear_i,
  output logic                       fire_o,
  input  wire logic [6:0][7:0]       slots_rest_i,
  output logic                       lib_sel_o,
  output logic [6:0]                 lib_id_o,
  output logic                       lib_step_o,
  input  wire logic [7:0]            lib_sample_i,
  input  wire logic                  lib_last_i,
  output logic                       drive_valid_o,
  input  wire logic                  drive_ready_i,
  output logic [7:0]                 drive_data_o
);
  import hpc_pkg::*;

  typedef struct packed {
    logic [7:0]           lib_cfg;
    logic [7:0]           rt_drive;
    logic [7:0]           slot_one;
    logic                 fire;
    hpc_state_e           state;
    logic [2:0]           slot_idx;
    logic [6:0]           wait_left;
    logic [HPC_CNT_W-1:0] cnt;
    logic                 rt_pending;
    logic                 push_v;
    logic [7:0]           push_d;
    hpc_reg_rsp_s         rsp;
    logic                 lib_step;
  } hpc_core_s;

  hpc_core_s st;
  hpc_core_s next_st;
  logic      fifo_in_ready;
  logic [7:0] cur_slot;
  logic       step_tick;
  logic       unit_tick;

  // Slot fetch is used for both the start of playback and each advance
  function automatic logic [7:0] slot_at(input logic [2:0] idx,
                                         input logic [7:0] first,
                                         input logic [6:0][7:0] rest);
    if (idx == 3'h0) begin
      return first;
    end
    return rest[idx - 3'h1];
  endfunction

  // Weight 4,3,2,1 then divide by 4; arithmetic so negative samples stay
  // negative. Truncation toward minus infinity is accepted for small values.
  function automatic logic [7:0] attenuate(input logic [7:0] s,
                                           input logic [1:0] code);
    logic signed [10:0] prod;
    prod = 11'(signed'(s)) * 11'(signed'({1'b0, 3'(3'h4 - {1'b0, code})}));
    return prod[9:2];
  endfunction

  // Slot contents are read live; a host rewrite during play takes effect
  assign cur_slot  = slot_at(st.slot_idx, st.slot_one, slots_rest_i);
  assign step_tick = st.lib_cfg[HPC_INTERVAL_BIT] ?
                     (st.cnt >= HPC_CNT_W'(STEP_FAST_CYC - 1)) :
                     (st.cnt >= HPC_CNT_W'(STEP_SLOW_CYC - 1));
  assign unit_tick = (st.cnt >= HPC_CNT_W'(WAIT_UNIT_CYC - 1));

  always_comb begin
    next_st          = st;
    next_st.rsp      = '0;
    next_st.lib_step = 1'b0;

    // Pending sample leaves once the FIFO takes it; engine stalls until then
    if (st.push_v && fifo_in_ready) begin
      next_st.push_v = 1'b0;
    end

    // All eight bits stored, reserved ones included
    if (reg_req_i.we) begin
      case (reg_req_i.addr)
        HPC_LIB_CFG_OFS:  next_st.lib_cfg  = reg_req_i.wdata;
        HPC_RT_DRIVE_OFS: begin
          next_st.rt_drive   = reg_req_i.wdata;
          next_st.rt_pending = 1'b1;
        end
        HPC_SLOT_ONE_OFS: next_st.slot_one = reg_req_i.wdata;
        default:          next_st.rt_pending = st.rt_pending;
      endcase
    end
    if (reg_req_i.re) begin
      next_st.rsp.valid = 1'b1;
      case (reg_req_i.addr)
        HPC_LIB_CFG_OFS:  next_st.rsp.data = st.lib_cfg;
        HPC_RT_DRIVE_OFS: next_st.rsp.data = st.rt_drive;
        HPC_SLOT_ONE_OFS: next_st.rsp.data = st.slot_one;
        default:          next_st.rsp.data = 8'h00;
      endcase
    end

    case (st.state)
      HPC_IDLE: begin
        // Counter parked at zero: the first step comes a full period later
        next_st.cnt = '0;
        if (fire_set_i) begin
          next_st.fire     = 1'b1;
          next_st.slot_idx = 3'h0;
          if (mode_i == HPC_MODE_LIVE) begin
            next_st.state      = HPC_LIVE;
            next_st.rt_pending = 1'b1;
          end else if (mode_i == HPC_MODE_SEQ) begin
            next_st.state = HPC_PLAY;
          end else begin
            // Other processes belong elsewhere and complete at once
            next_st.fire = 1'b0;
          end
        end
      end

      HPC_LIVE: begin
        // Each write, and the trigger itself, sends the raw value; writes made while the FIFO is full send only the latest
        if (st.rt_pending && !(st.push_v && !fifo_in_ready)) begin
          next_st.push_v = 1'b1;
          next_st.push_d = st.rt_drive;
          next_st.rt_pending = reg_req_i.we &&
                               (reg_req_i.addr == HPC_RT_DRIVE_OFS);
        end
      end

      HPC_PLAY: begin
        // Delay flag goes first, so a zero delay still counts as a wait
        if (cur_slot[HPC_DELAY_BIT]) begin
          next_st.state     = HPC_WAIT;
          next_st.wait_left = cur_slot[6:0];
          next_st.cnt       = '0;
        end else if (cur_slot[6:0] == 7'h00) begin
          next_st.state = HPC_IDLE;
          next_st.fire  = 1'b0;
        end else if (!step_tick) begin
          next_st.cnt = st.cnt + 1'b1;
        end else if (!(st.push_v && !fifo_in_ready)) begin
          next_st.cnt      = '0;
          next_st.push_v   = 1'b1;
          next_st.push_d   = attenuate(lib_sample_i,
                               st.lib_cfg[HPC_ATTEN_LSB +: 2]);
          next_st.lib_step = 1'b1;
          if (lib_last_i) begin
            if (st.slot_idx == 3'(HPC_SLOTS - 1)) begin
              next_st.state = HPC_IDLE;
              next_st.fire  = 1'b0;
            end else begin
              next_st.slot_idx = st.slot_idx + 1'b1;
            end
          end
        end
      end

      HPC_WAIT: begin
        // One idle unit per counter wrap; a zero delay passes straight on
        if (st.wait_left == 7'h00) begin
          next_st.cnt = '0;
          if (st.slot_idx == 3'(HPC_SLOTS - 1)) begin
            next_st.state = HPC_IDLE;
            next_st.fire  = 1'b0;
          end else begin
            next_st.state    = HPC_PLAY;
            next_st.slot_idx = st.slot_idx + 1'b1;
          end
        end else if (unit_tick) begin
          next_st.cnt       = '0;
          next_st.wait_left = st.wait_left - 1'b1;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end

      default: next_st.state = HPC_IDLE;
    endcase


    // Software clear aborts at once; a set in the same cycle wins
    if (fire_clear_i && !fire_set_i) begin
      next_st.fire       = 1'b0;
      next_st.state      = HPC_IDLE;
      next_st.rt_pending = 1'b0;
      next_st.cnt        = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    // Register fields take their own reset values after the blanket clear
    if (!rst_n_i) begin
      st          <= '0;
      st.lib_cfg  <= HPC_LIB_CFG_RST;
      st.rt_drive <= HPC_RT_DRIVE_RST;
      st.slot_one <= HPC_SLOT_ONE_RST;
      st.state    <= HPC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Queue absorbs host write bursts while the load is busy
  hpc_fifo #(
    .W (HPC_FIFO_W),
    .D (HPC_FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (st.push_v),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (st.push_d),
    .out_valid_o (drive_valid_o),
    .out_ready_i (drive_ready_i),
    .out_data_o  (drive_data_o)
  );


  // Status and answer outputs come straight from flops, except lib_id_o, which decodes slots_rest_i through cur_slot
  assign reg_rsp_o  = st.rsp;
  assign fire_o     = st.fire;
  assign lib_sel_o  = st.lib_cfg[HPC_LIB_SEL_BIT];
  assign lib_id_o   = st.slot_idx == 3'h0 ? st.slot_one[6:0] : cur_slot[6:0];
  assign lib_step_o = st.lib_step;
endmodule

// [verification/hpc_playback_regs_props.sv]
`timescale 1ns/100ps
module hpc_playback_regs_props (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire hpc_pkg::hpc_reg_req_s reg_req_i,
  input wire hpc_pkg::hpc_reg_rsp_s reg_rsp_o,
  input wire logic [1:0]            mode_i,
  input wire logic                  fire_set_i,
  input wire logic                  fire_clear_i,
  input wire logic                  fire_o,
  input wire logic                  lib_sel_o,
  input wire logic                  lib_step_o,
  input wire logic                  drive_valid_o,
  input wire logic                  drive_ready_i,
  input wire logic [7:0]            drive_data_o
);
  import hpc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rsp_latency: assert property (reg_req_i.re |=> reg_rsp_o.valid)
    else $error("read answer missing");
  a_rsp_quiet: assert property (!reg_req_i.re |=> !reg_rsp_o.valid)
    else $error("spurious read answer");
  a_cfg_readback: assert property (reg_req_i.re && !reg_req_i.we
    && reg_req_i.addr == HPC_LIB_CFG_OFS |=> reg_rsp_o.data[7] == lib_sel_o)
    else $error("library choice differs from register");
  a_fire_start: assert property (fire_set_i && !fire_o
    && mode_i < 2'h2 |=> fire_o)
    else $error("fire did not start");
  a_fire_cancel: assert property (fire_clear_i && !fire_set_i
    |=> !fire_o)
    else $error("cancel ignored");
  a_step_spacing: assert property (lib_step_o |=> !lib_step_o[*3])
    else $error("library steps too close");
  a_live_no_step: assert property (fire_o
    && mode_i == HPC_MODE_LIVE |-> !lib_step_o)
    else $error("library stepped in live mode");
  a_idle_no_step: assert property (!fire_o && !$past(fire_o)
    |-> !lib_step_o)
    else $error("library stepped while idle");
  a_drive_hold: assert property (drive_valid_o && !drive_ready_i
    |=> drive_valid_o && $stable(drive_data_o))
    else $error("stalled sample changed");
  c_live_out: cover property (fire_o && mode_i == 2'h1 && drive_valid_o);
  c_step: cover property (lib_step_o);
  c_cancel: cover property (fire_clear_i && fire_o);
endmodule
bind hpc_playback_regs hpc_playback_regs_props u_hpc_playback_regs_props (
  .clk_i, .rst_n_i, .reg_req_i, .reg_rsp_o, .mode_i, .fire_set_i,
  .fire_clear_i, .fire_o, .lib_sel_o, .lib_step_o, .drive_valid_o,
  .drive_ready_i, .drive_data_o);

// [verification/hpc_lib_model.sv]
`timescale 1ns/100ps
module hpc_lib_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       lib_step_i,
  input  wire logic       stall_i,
  output logic [7:0]      lib_sample_o,
  output logic            lib_last_o,
  output logic            drive_ready_o
);
  logic [1:0] cnt;
  // Negative sample so scaling must keep the sign
  assign lib_sample_o  = 8'hc0;
  // Three samples per effect, so a slot spans several steps
  assign lib_last_o    = cnt == 2'h2;
  assign drive_ready_o = !stall_i;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || (lib_step_i && lib_last_o))
      cnt <= 2'h0;
    else if (lib_step_i)
      cnt <= cnt + 2'h1;
  end
endmodule

// [verification/hpc_playback_regs_tb_top.sv]
`timescale 1ns/100ps
module hpc_playback_regs_tb_top;
  import hpc_pkg::*;
  logic            clk_i, rst_n_i, fire_set_i, fire_clear_i, stall;
  logic            fire_o, lib_sel_o, lib_step_o, lib_last_i;
  logic            drive_valid_o, drive_ready_i;
  hpc_reg_req_s    reg_req_i;
  hpc_reg_rsp_s    reg_rsp_o;
  logic [1:0]      mode_i;
  logic [6:0][7:0] slots_rest_i;
  logic [6:0]      lib_id_o;
  logic [7:0]      lib_sample_i, drive_data_o;
  int              num_errors, num_checks, n;

  hpc_playback_regs #(.STEP_SLOW_CYC(10), .STEP_FAST_CYC(4),
    .WAIT_UNIT_CYC(20)) u_hpc_playback_regs (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o),
    .mode_i(mode_i), .fire_set_i(fire_set_i), .fire_o(fire_o),
    .fire_clear_i(fire_clear_i), .slots_rest_i(slots_rest_i),
    .lib_sel_o(lib_sel_o), .lib_id_o(lib_id_o), .lib_step_o(lib_step_o),
    .lib_sample_i(lib_sample_i), .lib_last_i(lib_last_i),
    .drive_valid_o(drive_valid_o), .drive_ready_i(drive_ready_i),
    .drive_data_o(drive_data_o));
  hpc_lib_model u_hpc_lib_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .lib_step_i(lib_step_o), .stall_i(stall),
    .lib_sample_o(lib_sample_i), .lib_last_o(lib_last_i),
    .drive_ready_o(drive_ready_i));

  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    reg_req_i <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    reg_req_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    reg_req_i <= '0;
    #1 chk("rsp_valid", 8'h01, 8'(reg_rsp_o.valid));
    chk("rsp_data", e, reg_rsp_o.data);
  endtask
  task automatic fire(input logic [1:0] m);
    @(posedge clk_i);
    mode_i <= m;
    fire_set_i <= 1'b1;
    @(posedge clk_i);
    fire_set_i <= 1'b0;
  endtask
  // Waits for sample (0), step (1) or end of process (2)
  task automatic wait_ev(input int k);
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      #1;
      if ((k == 0 && drive_valid_o === 1'b1) ||
          (k == 1 && lib_step_o === 1'b1) || (k == 2 && fire_o === 1'b0))
        break;
    end
    if (n == 200) begin
      $display("CHECK FAILED wait %0d exp 1 got 0", k);
      num_errors++;
      end_sim();
    end
  endtask

  task automatic t_regs;
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'h7f);
    rd(8'h0f, 8'h01);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h0d, 8'hdc);
    rd(8'h0d, 8'hdc);
    chk("lib_sel", 8'h01, 8'(lib_sel_o));
    wr(8'h0d, 8'h5c);
    #1 chk("lib_sel", 8'h00, 8'(lib_sel_o));
  endtask
  task automatic t_live;
    wr(8'h0d, 8'h03);
    wr(8'h0e, 8'h80);
    fire(2'h1);
    wait_ev(0);
    chk("live", 8'h80, drive_data_o);
    @(posedge clk_i);
    stall <= 1'b1;
    wr(8'h0e, 8'h23);
    repeat (6) @(posedge clk_i);
    #1 chk("held", 8'h23, drive_data_o);
    @(posedge clk_i);
    stall <= 1'b0;
    @(posedge clk_i);
    fire_clear_i <= 1'b1;
    @(posedge clk_i);
    fire_clear_i <= 1'b0;
    #1 chk("cancel", 8'h00, 8'(fire_o));
  endtask
  task automatic t_seq;
    wr(8'h0d, 8'h21);
    wr(8'h0f, 8'h05);
    fire(2'h0);
    #1 chk("id", 8'h05, 8'(lib_id_o));
    wait_ev(0);
    chk("scaled", 8'hd0, drive_data_o);
    wait_ev(1);
    wait_ev(1);
    chk("period", 8'h03, 8'(n));
    wait_ev(2);
  endtask
  task automatic t_wait;
    wr(8'h0f, 8'h82);
    fire(2'h0);
    repeat (30) @(posedge clk_i);
    #1 chk("waiting", 8'h01, 8'(fire_o));
    wait_ev(2);
    chk("wait_end", 8'h01, 8'(n < 15));
  endtask
  task automatic t_misc;
    fire(2'h2);
    #1 chk("other_mode", 8'h00, 8'(fire_o));
    wr(8'h0d, 8'h03);
    wr(8'h0f, 8'h05);
    fire(2'h0);
    wait_ev(0);
    chk("quarter", 8'hf0, drive_data_o);
    wait_ev(1);
    wait_ev(1);
    chk("slow_period", 8'h09, 8'(n));
    wait_ev(2);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    reg_req_i = '0;
    mode_i = 2'h0;
    fire_set_i = 1'b0;
    fire_clear_i = 1'b0;
    slots_rest_i = '0;
    stall = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_live();
    t_seq();
    t_wait();
    t_misc();
    end_sim();
  end
endmodule
